// file: inc/asrc_pkg.sv
// Package for the host-side controller of a 128K x 8 asynchronous static memory.
// Assumes a 100 MHz controller clock; all pin timing is counted in its cycles.
package asrc_pkg;
  localparam int unsigned CLK_PERIOD_PS = 10000;
  localparam int unsigned ADDR_W = 17;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned MEM_WORDS = 131072;

  // Pin timing in picoseconds, as printed in ns times 1000
  localparam int unsigned T_READ_CYCLE_PS = 10000;
  localparam int unsigned T_WRITE_CYCLE_PS = 10000;
  localparam int unsigned T_ADDR_ACCESS_PS = 10000;
  localparam int unsigned T_WRITE_PULSE_PS = 9000;
  localparam int unsigned T_DATA_SETUP_PS = 5000;
  localparam int unsigned T_BUS_TURN_PS = 5000;

  function automatic int unsigned asrc_cyc_min(input int unsigned t_ps);
    int unsigned n;
    n = (t_ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (n < 1) ? 1 : n;
  endfunction

  // Access counts; one extra cycle covers the synchronous capture of data pins
  localparam int unsigned RD_CYC = asrc_cyc_min(T_ADDR_ACCESS_PS) + 1;
  localparam int unsigned WR_CYC = asrc_cyc_min(T_WRITE_PULSE_PS);
  localparam int unsigned TURN_CYC = asrc_cyc_min(T_BUS_TURN_PS);
  localparam int unsigned CYC_MIN = asrc_cyc_min(T_READ_CYCLE_PS);
  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] RD_CNT = CNT_W'(RD_CYC);
  localparam logic [CNT_W-1:0] WR_CNT = CNT_W'(WR_CYC);
  localparam logic [CNT_W-1:0] TURN_CNT = CNT_W'(TURN_CYC);

  // Write loop steps one bit at a time; a three-state read loop cannot close in Gray
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h0,
    ST_RD = 3'h4,
    ST_WR_SETUP = 3'h1,
    ST_WR_PULSE = 3'h3,
    ST_WR_END = 3'h2,
    ST_TURN = 3'h5
  } asrc_state_t;
endpackage

// file: rtl/asrc_ctrl.sv
// Host controller driving a 128K x 8 asynchronous SRAM through its pins.
// Assumes pin inputs are synchronous to i_mclk and the board delay is small against 10 ns.
//
// Behaviour
// - Reads hold write strobe high with chip select and output enable low.
// - Writes happen only while chip select and write strobe are both low.
// - Read cycle lasts at least 10 ns from address valid to change.
// - Write cycle lasts at least 10 ns from address valid to change.
// - Address valid 9 ns before strobe end; strobe low at least 9 ns.
// - Write data set up 5 ns before write end, held 0 ns after.
// - Chip select low 8 ns before write end, address valid 8 ns before.
// - Controller avoids driving the data bus while the memory drives it.
`timescale 1ns/10ps
module asrc_ctrl
(
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  // User request
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [asrc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [asrc_pkg::DATA_W-1:0] i_wdata,
  output logic o_ready,
  output logic o_rvalid,
  output logic [asrc_pkg::DATA_W-1:0] o_rdata,
  // Memory pins
  output logic [asrc_pkg::ADDR_W-1:0] o_addr_in,
  output logic o_cs_n,
  output logic o_we_n,
  output logic o_oe_n,
  input wire logic [asrc_pkg::DATA_W-1:0] i_data_io,
  output logic [asrc_pkg::DATA_W-1:0] o_data_io,
  output logic o_data_io_oe
);

  ////////////////////////////////////////////////////////////////////////////
  asrc_pkg::asrc_state_t state_reg;
  logic [asrc_pkg::CNT_W-1:0] cnt_reg;
  logic cnt_done;

  assign cnt_done = (cnt_reg == asrc_pkg::CNT_ONE);

  // One down-count step, shared by every counting phase
  function automatic logic [asrc_pkg::CNT_W-1:0] cnt_dec(input logic [asrc_pkg::CNT_W-1:0] c);
    return c - asrc_pkg::CNT_ONE;
  endfunction

  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      state_reg <= asrc_pkg::ST_IDLE;
      cnt_reg <= asrc_pkg::CNT_ZERO;
    end
    else if (i_ce)
    begin
      unique case (state_reg)
        asrc_pkg::ST_IDLE:
        begin
          if (i_req && i_we)
          begin
            state_reg <= asrc_pkg::ST_WR_SETUP;
          end
          else if (i_req)
          begin
            state_reg <= asrc_pkg::ST_RD;
            cnt_reg <= asrc_pkg::RD_CNT;
          end
        end
        asrc_pkg::ST_RD:
        begin
          cnt_reg <= cnt_dec(cnt_reg);
          if (cnt_done)
          begin
            state_reg <= asrc_pkg::ST_TURN;
            cnt_reg <= asrc_pkg::TURN_CNT;
          end
        end
        asrc_pkg::ST_WR_SETUP:
        begin
          state_reg <= asrc_pkg::ST_WR_PULSE;
          cnt_reg <= asrc_pkg::WR_CNT;
        end
        asrc_pkg::ST_WR_PULSE:
        begin
          cnt_reg <= cnt_dec(cnt_reg);
          if (cnt_done)
          begin
            state_reg <= asrc_pkg::ST_WR_END;
          end
        end
        asrc_pkg::ST_WR_END:
        begin
          state_reg <= asrc_pkg::ST_IDLE;
        end
        asrc_pkg::ST_TURN:
        begin
          cnt_reg <= cnt_dec(cnt_reg);
          if (cnt_done)
          begin
            state_reg <= asrc_pkg::ST_IDLE;
          end
        end
        default:
        begin
          state_reg <= asrc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin controls; select and strobes are all registered so no glitches reach the pins
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      o_cs_n <= 1'b1;
      o_we_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_data_io_oe <= 1'b0;
      o_addr_in <= '0;
      o_data_io <= '0;
    end
    else if (i_ce)
    begin
      unique case (state_reg)
        asrc_pkg::ST_IDLE:
        begin
          if (i_req)
          begin
            // Address and data change only here, outside the strobe
            o_addr_in <= i_addr;
            o_data_io <= i_wdata;
            o_cs_n <= 1'b0;
            o_oe_n <= i_we;
            o_we_n <= 1'b1;
            o_data_io_oe <= 1'b0;
          end
        end
        asrc_pkg::ST_RD:
        begin
          if (cnt_done)
          begin
            o_cs_n <= 1'b1;
            o_oe_n <= 1'b1;
          end
        end
        asrc_pkg::ST_WR_SETUP:
        begin
          // Output enable is already high, so memory pins float before we drive
          o_we_n <= 1'b0;
          o_data_io_oe <= 1'b1;
        end
        asrc_pkg::ST_WR_PULSE:
        begin
          if (cnt_done)
          begin
            o_we_n <= 1'b1;
          end
        end
        asrc_pkg::ST_WR_END:
        begin
          // Select rises after strobe, data released one cycle after strobe end
          o_cs_n <= 1'b1;
          o_data_io_oe <= 1'b0;
        end
        asrc_pkg::ST_TURN:
        begin
          o_cs_n <= 1'b1;
        end
        default:
        begin
          o_cs_n <= 1'b1;
          o_we_n <= 1'b1;
          o_oe_n <= 1'b1;
          o_data_io_oe <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // User handshake and read capture
  always_ff @(posedge i_mclk)
  begin
    if (!i_reset_n)
    begin
      o_ready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= '0;
    end
    else if (i_ce)
    begin
      o_rvalid <= 1'b0;
      // Ready is advisory; a request is only ever taken in IDLE
      o_ready <= (state_reg == asrc_pkg::ST_IDLE && !i_req) ||
                 (state_reg == asrc_pkg::ST_WR_END) ||
                 (state_reg == asrc_pkg::ST_TURN && cnt_done);
      if (state_reg == asrc_pkg::ST_RD && cnt_done)
      begin
        o_rdata <= i_data_io;
        o_rvalid <= 1'b1;
      end
    end
  end

endmodule

// file: dv/asrc_ctrl_props.sv
// Pin checks for the SRAM host controller.
// Bound to asrc_ctrl; sees only its ports.
`timescale 1ns/10ps
module asrc_ctrl_props
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Memory pins
  input wire logic [16:0] o_addr_in,
  input wire logic o_cs_n,
  input wire logic o_we_n,
  input wire logic o_oe_n,
  input wire logic [7:0] i_data_io,
  input wire logic [7:0] o_data_io,
  input wire logic o_data_io_oe,
  // Read result
  input wire logic o_rvalid,
  input wire logic [7:0] o_rdata
);
  // Read answer lands this many cycles after output enable falls
  localparam int RD_LAT = asrc_pkg::RD_CYC;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);
  AST_RD_WE: assert property (!o_cs_n && !o_oe_n |-> o_we_n)
    else $error("write strobe low during read");
  AST_WR_CS: assert property (!o_we_n |-> !o_cs_n && o_oe_n)
    else $error("strobe low outside select");
  AST_NO_FIGHT: assert property (o_data_io_oe |-> o_oe_n)
    else $error("bus driven with output enabled");
  AST_RD_HOLD: assert property ($fell(o_oe_n) |=> (!o_oe_n && !o_cs_n && $stable(o_addr_in)) ##1 $stable(o_addr_in))
    else $error("read cycle too short");
  AST_RD_LEN: assert property ($fell(o_oe_n) |-> ##RD_LAT (o_rvalid && o_oe_n))
    else $error("read answer off time");
  AST_RD_DATA: assert property (o_rvalid |-> o_rdata == $past(i_data_io))
    else $error("read byte not from pins");
  AST_WP_LEN: assert property ($fell(o_we_n) |=> o_we_n)
    else $error("strobe width wrong");
  AST_WR_SETUP: assert property ($fell(o_we_n) |-> $stable(o_addr_in) && !$past(o_cs_n))
    else $error("address or select late");
  AST_WR_DRIVE: assert property (!o_we_n |-> o_data_io_oe)
    else $error("data not driven in strobe");
  AST_WR_END: assert property ($rose(o_we_n) |-> o_data_io_oe && !o_cs_n && $stable(o_data_io))
    else $error("data or select dropped at write end");
endmodule
bind asrc_ctrl asrc_ctrl_props u_asrc_ctrl_props (.*);

// file: dv/asrc_sram_model.sv
// Behavioural 128K x 8 asynchronous SRAM.
// No pull on the data pins: floating shows the last byte inverted.
`timescale 1ns/10ps
module asrc_sram_model
#(
  parameter int unsigned T_ACC = 10
)
(
  input wire logic [16:0] i_addr_in,
  input wire logic i_cs_n,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  input wire logic [7:0] i_d,
  output logic [7:0] o_q
);
  logic [7:0] mem [131072];
  logic [7:0] rd;
  logic [7:0] last = 8'h00;
  wire wr = !i_cs_n && !i_we_n;
  wire drv = !i_cs_n && !i_oe_n && i_we_n;
  always @(negedge wr) mem[i_addr_in] = i_d;
  assign #(T_ACC) rd = mem[i_addr_in];
  always @(rd) if (drv) last = rd;
  assign o_q = drv ? rd : ~last;
endmodule

// file: dv/test_asrc_ctrl.sv
// Bench for asrc_ctrl with the SRAM model on its pins.
// Read latency is the package access count; the memory model answers within 10 ns.
`timescale 1ns/10ps
module test_asrc_ctrl;
  logic i_mclk = 0, i_reset_n = 0, i_ce = 1, i_req = 0, i_we = 0;
  logic [16:0] i_addr = 0, o_addr_in;
  logic [7:0] i_wdata = 0, i_data_io, o_data_io, o_rdata, mq;
  logic o_ready, o_rvalid, o_cs_n, o_we_n, o_oe_n, o_data_io_oe;
  int fails = 0, checks = 0, cyc = 0;
  assign i_data_io = o_data_io_oe ? o_data_io : mq;
  asrc_ctrl u_asrc_ctrl (.*);
  asrc_sram_model u_asrc_sram_model (.i_addr_in(o_addr_in), .i_cs_n(o_cs_n), .i_we_n(o_we_n),
    .i_oe_n(o_oe_n), .i_d(i_data_io), .o_q(mq));
  initial forever #5 i_mclk = ~i_mclk;
  // Whole run is about a hundred cycles
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checks++;
    if (s !== e) $display("ERROR %s exp %h seen %h", n, e, s);
    if (s !== e) fails++;
  endtask
  task automatic go(logic w, logic [16:0] a, logic [7:0] d);
    // Step off the edge so ready is read after it has settled
    #1;
    while (o_ready !== 1'b1) @(posedge i_mclk) #1;
    @(posedge i_mclk);
    {i_req, i_we, i_addr, i_wdata} <= {1'b1, w, a, d};
    @(posedge i_mclk);
    i_req <= 0;
  endtask
  task automatic rd(logic [16:0] a, logic [7:0] e);
    int n;
    go(0, a, 0);
    n = 0;
    do
    begin
      @(posedge i_mclk) #1;
      n++;
    end while (o_rvalid !== 1'b1 && n < 20);
    chk("rlat", n, asrc_pkg::RD_CYC);
    chk("rdata", o_rdata, e);
  endtask
  task automatic t_rw();
    logic [16:0] a [3] = '{17'h00000, 17'h1ffff, 17'h0aaaa};
    logic [7:0] d [3] = '{8'ha5, 8'h5a, 8'h3c};
    chk("idle", {o_cs_n, o_we_n, o_oe_n, o_data_io_oe}, 4'he);
    for (int i = 0; i < 3; i++)
    begin
      go(1, a[i], d[i]);
      rd(a[i], d[i]);
    end
    for (int i = 0; i < 3; i++)
      rd(a[i], d[i]);
    $display("test rw done");
  endtask
  task automatic t_refuse();
    go(1, 17'h00111, 8'h5a);
    go(0, 17'h00000, 8'h00);
    @(posedge i_mclk);
    {i_req, i_we, i_addr, i_wdata} <= {2'b11, 17'h00111, 8'hff};
    @(posedge i_mclk);
    i_req <= 0;
    rd(17'h00111, 8'h5a);
    @(posedge i_mclk);
    i_ce <= 0;
    go(1, 17'h00111, 8'h77);
    repeat (3) @(posedge i_mclk) #1;
    chk("frozen", {o_cs_n, o_ready}, 2'h3);
    @(posedge i_mclk);
    i_ce <= 1;
    rd(17'h00111, 8'h5a);
    $display("test refuse done");
  endtask
  task automatic t_walk();
    go(1, 17'h15555, 8'hc3);
    #1;
    chk("wsetup", {o_cs_n, o_we_n, o_oe_n, o_data_io_oe}, 4'h6);
    chk("waddr", o_addr_in, 17'h15555);
    repeat (asrc_pkg::WR_CYC)
    begin
      @(posedge i_mclk) #1;
      chk("wpulse", {o_cs_n, o_we_n, o_oe_n, o_data_io_oe}, 4'h3);
      chk("wdata", i_data_io, 8'hc3);
    end
    @(posedge i_mclk) #1;
    chk("wend", {o_cs_n, o_we_n, o_oe_n, o_data_io_oe}, 4'h7);
    @(posedge i_mclk) #1;
    chk("wfree", {o_cs_n, o_we_n, o_oe_n, o_data_io_oe, o_ready}, 5'h1d);
    go(0, 17'h15555, 8'h00);
    repeat (asrc_pkg::RD_CYC)
    begin
      #1;
      chk("rpins", {o_cs_n, o_we_n, o_oe_n, o_data_io_oe, o_rvalid}, 5'h08);
      chk("raddr", o_addr_in, 17'h15555);
      @(posedge i_mclk);
    end
    #1;
    chk("rdone", {o_cs_n, o_we_n, o_oe_n, o_data_io_oe, o_rvalid}, 5'h1d);
    chk("rbyte", o_rdata, 8'hc3);
    @(posedge i_mclk) #1;
    chk("rturn", {o_rvalid, o_ready}, 2'h1);
    $display("test walk done");
  endtask
  task automatic t_reset();
    go(0, 17'h0aaaa, 8'h00);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    #1;
    chk("rst_pins", {o_cs_n, o_we_n, o_oe_n, o_data_io_oe, o_ready, o_rvalid}, 6'h38);
    chk("rst_addr", o_addr_in, 17'h00000);
    @(posedge i_mclk) #1;
    chk("rst_ready", o_ready, 1'b1);
    rd(17'h0aaaa, 8'h3c);
    $display("test reset done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge i_mclk);
    i_reset_n <= 1;
    @(posedge i_mclk) #1;
    t_rw();
    t_refuse();
    t_walk();
    t_reset();
    tally_and_finish();
  end
endmodule
